// *** include/i2cbt_pkg.sv ***
// Constants, types and timing functions of the two-wire bit timing generator
// What this block does
// - All timing except the fixed STOP setup and the input filter delay derives from selected decimal divider
// - Select code maps to tabulated divider value
// - Codes 0x01 and 0x24 give the same divider and output rate
// - Master clock low and high each half divider
// - START hold is divider/16 halved below limit
// - Repeated START setup is divider plus START hold
// - STOP setup at least four clocks high
// - Inputs qualified with 2*rate+1 cycle delay
// - Filter samples every rate memory clocks
// - Lines only pulled low or released
// - Counters count memory clock cycles only
// - Slave waits set cycles before stretching clock
package i2cbt_pkg;

    localparam int DSEL_W        = 6;
    localparam int CNT_W         = 17;
    localparam int SEL_HIGH_BIT  = 5;
    localparam int SEL_MID_BIT   = 1;
    localparam int SEL_EXP_LSB   = 2;
    localparam int STOP_SETUP_CYC = 4;
    localparam int HOLD_BASE_CYC = 8;
    localparam int HOLD_UNIT_CYC = 16;
    localparam int SHOLD_LIM_LO  = 16;
    localparam int SHOLD_LIM_HI  = 9;
    localparam int BASE_LO       = 32;
    localparam int BASE_HI       = 16;

    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b000,
        ST_SHOLD = 3'b001,
        ST_LOW   = 3'b010,
        ST_HIGH  = 3'b011,
        ST_OWN   = 3'b100
    } i2cbt_state_type;

    // Start from idle gives START; start while owning gives repeated START
    typedef enum logic [1:0]
    {
        OP_START = 2'b00,
        OP_BIT   = 2'b01,
        OP_STOP  = 2'b10
    } i2cbt_op_type;

    typedef struct packed
    {
        logic scl;
        logic sda;
    } i2cbt_line_type;

    // code to tabulated divider
    // Codes 0x22 and 0x1f break the multiplier pattern of their neighbours
    function automatic logic [CNT_W-1:0] div_value(input logic [DSEL_W-1:0] sel);
        logic [CNT_W-1:0] m;
        logic [CNT_W-1:0] base;
        m = '0;
        base = '0;
        if (sel[SEL_HIGH_BIT])
        begin
            case (sel[1:0])
                2'h0:    m = CNT_W'(10);
                2'h1:    m = CNT_W'(12);
                2'h2:    m = (sel[4:2] == 3'h0) ? CNT_W'(14) : CNT_W'(15);
                default: m = CNT_W'(16);
            endcase
            base = CNT_W'(BASE_HI);
        end
        else
        begin
            case (sel[1:0])
                2'h0:    m = CNT_W'(9);
                2'h1:    m = CNT_W'(10);
                2'h2:    m = CNT_W'(12);
                default: m = (sel[4:2] == 3'h7) ? CNT_W'(15) : CNT_W'(14);
            endcase
            base = CNT_W'(BASE_LO);
        end
        return CNT_W'((m * base) << sel[4:2]);
    endfunction : div_value

    // Master hold and slave wait share one form, with differing factor maps
    function automatic logic [CNT_W-1:0] hold_cycles(input logic [DSEL_W-1:0] sel,
                                                     input logic slave);
        int f;
        f = 0;
        case ({sel[SEL_HIGH_BIT], sel[SEL_MID_BIT]})
            2'b10:   f = 1;
            2'b11:   f = slave ? 5 : 2;
            2'b00:   f = slave ? 2 : 3;
            default: f = slave ? 3 : 4;
        endcase
        return CNT_W'(HOLD_BASE_CYC + ((HOLD_UNIT_CYC << sel[4:2]) * f));
    endfunction : hold_cycles

    function automatic logic [CNT_W-1:0] shold_cycles(input logic [DSEL_W-1:0] sel,
                                                      input logic [CNT_W-1:0] div);
        logic [CNT_W-1:0] v;
        logic [CNT_W-1:0] lim;
        v = div >> 4;
        lim = sel[SEL_HIGH_BIT] ? CNT_W'(SHOLD_LIM_HI) : CNT_W'(SHOLD_LIM_LO);
        for (int i = 0; i < 16; i++)
        begin
            if (v >= lim)
                v = v >> 1;
        end
        return v;
    endfunction : shold_cycles

endpackage : i2cbt_pkg

// *** src/i2cbt_gen.sv ***
// Two-wire bit timing generator: input filter, master bit engine, slave stretch
`timescale 1ns/100ps
`default_nettype none
module i2cbt_gen #(
    parameter int FSR_W = 6
) (
    input  wire logic                            clk,
    input  wire logic                            sys_rst,
    input  wire logic [i2cbt_pkg::DSEL_W-1:0]    divider_select_field,
    input  wire logic [FSR_W-1:0]                filter_sample_rate,
    input  wire logic                            cmd_valid,
    input  wire i2cbt_pkg::i2cbt_op_type         cmd_op,
    input  wire logic                            cmd_bit,
    output logic                                 cmd_ready,
    output logic                                 done,
    output logic                                 rx_bit,
    output logic                                 bus_owned,
    input  wire logic                            slave_tx_stretch,
    input  wire i2cbt_pkg::i2cbt_line_type       line_in,
    output i2cbt_pkg::i2cbt_line_type            line_out,
    output i2cbt_pkg::i2cbt_line_type            line_oe
);

    if (FSR_W < 1 || FSR_W > 16)
    begin : g_chk
        $error("filter_sample_rate width out of range");
    end

    localparam int CW = i2cbt_pkg::CNT_W;

    logic [FSR_W-1:0]          fcnt_q;
    logic [FSR_W-1:0]          fcnt_d;
    wire  [FSR_W-1:0]          fper = (filter_sample_rate == '0) ? FSR_W'(1) : filter_sample_rate;
    wire                       tick = (fcnt_q == '0);
    assign fcnt_d = tick ? FSR_W'(fper - FSR_W'(1)) : FSR_W'(fcnt_q - FSR_W'(1));

    // one register plus two samples give 2*rate+1
    i2cbt_pkg::i2cbt_line_type in_q;
    i2cbt_pkg::i2cbt_line_type s0_q;
    i2cbt_pkg::i2cbt_line_type s1_q;
    wire  qscl = s1_q.scl;
    wire  qsda = s1_q.sda;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            fcnt_q <= '0;
            in_q   <= '1;
            s0_q   <= '1;
            s1_q   <= '1;
        end
        else
        begin
            fcnt_q <= fcnt_d;
            in_q   <= line_in;
            if (tick)
            begin
                s0_q <= in_q;
                s1_q <= s0_q;
            end
        end
    end

    wire [CW-1:0] div_c   = i2cbt_pkg::div_value(divider_select_field);
    wire [CW-1:0] half_c  = div_c >> 1;
    wire [CW-1:0] hold_c  = i2cbt_pkg::hold_cycles(divider_select_field, 1'b0);
    wire [CW-1:0] sh_c    = i2cbt_pkg::shold_cycles(divider_select_field, div_c);
    wire [CW-1:0] rs_c    = CW'(div_c + sh_c);
    wire [CW-1:0] slow_c  = i2cbt_pkg::hold_cycles(divider_select_field, 1'b1);

    i2cbt_pkg::i2cbt_state_type st_q;
    i2cbt_pkg::i2cbt_state_type st_d;
    i2cbt_pkg::i2cbt_op_type    op_q;
    logic [CW-1:0]              cnt_q;
    logic                       bit_q;
    logic                       mscl_q;
    logic                       msda_q;
    logic                       done_q;
    logic                       rx_q;

    // stop setup comes from the filtered high time
    wire [CW-1:0] high_lim = (op_q == i2cbt_pkg::OP_BIT)   ? half_c :
                             (op_q == i2cbt_pkg::OP_START) ? rs_c :
                             CW'(i2cbt_pkg::STOP_SETUP_CYC);
    wire low_end   = (st_q == i2cbt_pkg::ST_LOW) && (cnt_q == CW'(half_c - CW'(1)));
    wire hold_hit  = (st_q == i2cbt_pkg::ST_LOW) && (cnt_q == hold_c);
    wire high_end  = (st_q == i2cbt_pkg::ST_HIGH) && qscl && (cnt_q == CW'(high_lim - CW'(1)));
    wire shold_end = (st_q == i2cbt_pkg::ST_SHOLD) && (cnt_q == CW'(sh_c - CW'(1)));
    wire accept    = cmd_valid && cmd_ready;
    wire sda_tgt   = (op_q == i2cbt_pkg::OP_BIT) ? ~bit_q : (op_q == i2cbt_pkg::OP_STOP);

    assign cmd_ready = (st_q == i2cbt_pkg::ST_IDLE) || (st_q == i2cbt_pkg::ST_OWN);

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            i2cbt_pkg::ST_IDLE:
                if (accept && cmd_op == i2cbt_pkg::OP_START)
                    st_d = i2cbt_pkg::ST_SHOLD;
            i2cbt_pkg::ST_OWN:
                if (accept)
                    st_d = i2cbt_pkg::ST_LOW;
            i2cbt_pkg::ST_SHOLD:
                if (shold_end)
                    st_d = i2cbt_pkg::ST_OWN;
            i2cbt_pkg::ST_LOW:
                if (low_end)
                    st_d = i2cbt_pkg::ST_HIGH;
            i2cbt_pkg::ST_HIGH:
                if (high_end)
                    st_d = (op_q == i2cbt_pkg::OP_BIT)   ? i2cbt_pkg::ST_OWN :
                           (op_q == i2cbt_pkg::OP_START) ? i2cbt_pkg::ST_SHOLD :
                           i2cbt_pkg::ST_IDLE;
            default:
                st_d = i2cbt_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_q   <= i2cbt_pkg::ST_IDLE;
            op_q   <= i2cbt_pkg::OP_BIT;
            cnt_q  <= '0;
            bit_q  <= 1'b1;
            mscl_q <= 1'b0;
            msda_q <= 1'b0;
            done_q <= 1'b0;
            rx_q   <= 1'b1;
        end
        else
        begin
            st_q   <= st_d;
            done_q <= 1'b0;
            // count memory clocks; high phase waits for the line itself
            if (st_d != st_q || (st_q == i2cbt_pkg::ST_HIGH && !qscl))
                cnt_q <= '0;
            else
                cnt_q <= CW'(cnt_q + CW'(1));
            if (accept)
            begin
                op_q  <= cmd_op;
                bit_q <= cmd_bit;
            end
            if (accept && st_q == i2cbt_pkg::ST_IDLE && cmd_op == i2cbt_pkg::OP_START)
                msda_q <= 1'b1;
            // data changes only after the hold
            if (hold_hit)
                msda_q <= sda_tgt;
            if (low_end)
                mscl_q <= 1'b0;
            if (shold_end)
            begin
                mscl_q <= 1'b1;
                done_q <= 1'b1;
            end
            if (high_end)
            begin
                case (op_q)
                    i2cbt_pkg::OP_BIT:
                    begin
                        rx_q   <= qsda;
                        mscl_q <= 1'b1;
                        done_q <= 1'b1;
                    end
                    i2cbt_pkg::OP_START:
                        msda_q <= 1'b1;
                    default:
                    begin
                        msda_q <= 1'b0;
                        done_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    // slave stretch a set wait after the external clock fall
    logic          sdrv_q;
    logic          pscl_q;
    logic          swait_q;
    logic [CW-1:0] scnt_q;
    wire scl_fall = pscl_q && !qscl;
    wire sl_armed = slave_tx_stretch && (st_q == i2cbt_pkg::ST_IDLE);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sdrv_q  <= 1'b0;
            pscl_q  <= 1'b1;
            swait_q <= 1'b0;
            scnt_q  <= '0;
        end
        else
        begin
            pscl_q <= qscl;
            if (!sl_armed)
            begin
                sdrv_q  <= 1'b0;
                swait_q <= 1'b0;
            end
            else if (scl_fall && !sdrv_q)
            begin
                swait_q <= 1'b1;
                scnt_q  <= '0;
            end
            else if (swait_q)
            begin
                scnt_q <= CW'(scnt_q + CW'(1));
                if (scnt_q == CW'(slow_c - CW'(1)))
                begin
                    swait_q <= 1'b0;
                    sdrv_q  <= 1'b1;
                end
            end
        end
    end

    // open drain: data always low, enables pull
    assign line_out   = '0;
    assign line_oe    = '{scl: mscl_q | sdrv_q, sda: msda_q};
    assign done       = done_q;
    assign rx_bit     = rx_q;
    assign bus_owned  = (st_q != i2cbt_pkg::ST_IDLE);

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_div_code;
        (divider_select_field == 6'h20) |-> (div_c == 17'h000a0);
    endproperty
    a_div_code: assert property (p_div_code) else $error("divider code map wrong");

    property p_div_top;
        (divider_select_field == 6'h1f) |-> (div_c == 17'h0f000) && (half_c == 17'h07800);
    endproperty
    a_div_top: assert property (p_div_top) else $error("top divider wrong");

    property p_distinct;
        (divider_select_field == 6'h01) |-> (half_c == 17'h000a0) &&
            (div_c != i2cbt_pkg::div_value(6'h00));
    endproperty
    a_distinct: assert property (p_distinct) else $error("dividers collide");

    property p_low_half;
        low_end |=> (st_q == i2cbt_pkg::ST_HIGH) && !line_oe.scl && (cnt_q == '0);
    endproperty
    a_low_half: assert property (p_low_half) else $error("low phase length wrong");

    property p_hold;
        $changed(line_oe.sda) && $past(st_q == i2cbt_pkg::ST_LOW)
            |-> $past(cnt_q) == hold_c;
    endproperty
    a_hold: assert property (p_hold) else $error("data moved before hold");

    property p_shold;
        $rose(line_oe.scl) && $past(st_q == i2cbt_pkg::ST_SHOLD)
            |-> $past(cnt_q) == CW'(sh_c - CW'(1));
    endproperty
    a_shold: assert property (p_shold) else $error("start hold wrong");

    property p_rs;
        (st_q == i2cbt_pkg::ST_HIGH) && (op_q == i2cbt_pkg::OP_START) ##1
            (st_q == i2cbt_pkg::ST_SHOLD) |-> $past(cnt_q) == CW'(rs_c - CW'(1));
    endproperty
    a_rs: assert property (p_rs) else $error("repeated start setup short");

    property p_stop;
        $fell(line_oe.sda) && $past(st_q == i2cbt_pkg::ST_HIGH)
            |-> $past(qscl, 4) && $past(qscl, 3) && $past(qscl, 2) && $past(qscl);
    endproperty
    a_stop: assert property (p_stop) else $error("stop setup short");

    property p_filt;
        $changed(qscl) |-> $past(tick);
    endproperty
    a_filt: assert property (p_filt) else $error("filter changed off tick");

    property p_drive_low;
        line_out == '0;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("line driven high");

    property p_slave;
        $rose(sdrv_q) |-> $past(scnt_q) == CW'(slow_c - CW'(1)) && !qscl;
    endproperty
    a_slave: assert property (p_slave) else $error("slave stretch early");

    c_start: cover property ($rose(bus_owned) ##[1:300] done);
    c_bit:   cover property ((st_q == i2cbt_pkg::ST_HIGH) && (op_q == i2cbt_pkg::OP_BIT) && high_end);
    c_rs:    cover property (high_end && (op_q == i2cbt_pkg::OP_START));
    c_slave: cover property ($rose(sdrv_q));

endmodule : i2cbt_gen
`default_nettype wire

// *** bench/i2cbt_bus_peer.sv ***
// Open-drain bus peer: far-side slave or master on the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module i2cbt_bus_peer (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire i2cbt_pkg::i2cbt_line_type wire_lvl,
    input  wire logic                      pull_sda,
    input  wire logic                      grab_scl,
    input  wire logic [16:0]               stretch,
    output i2cbt_pkg::i2cbt_line_type      peer_oe
);
    logic        scl_prev_q;
    logic        sda_pull_q;
    logic [16:0] hold_cnt_q;

    assign peer_oe.scl = grab_scl | (hold_cnt_q != 17'h00000);
    assign peer_oe.sda = sda_pull_q;

    // Data moves only after a clock fall, so it never fakes a condition
    always_ff @(posedge clk)
    begin
        scl_prev_q <= sys_rst | wire_lvl.scl;
        if (sys_rst)
        begin
            sda_pull_q <= 1'b0;
            hold_cnt_q <= 17'h00000;
        end
        else if (scl_prev_q && !wire_lvl.scl)
        begin
            sda_pull_q <= pull_sda;
            hold_cnt_q <= stretch;
        end
        else if (hold_cnt_q != 17'h00000)
            hold_cnt_q <= hold_cnt_q - 17'h00001;
    end
endmodule : i2cbt_bus_peer
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench of the two-wire bit timing generator
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic                      clk;
    logic                      sys_rst;
    logic [5:0]                dsel;
    logic [5:0]                fsr;
    logic                      cmd_valid;
    i2cbt_pkg::i2cbt_op_type   cmd_op;
    logic                      cmd_bit;
    logic                      cmd_ready;
    logic                      done;
    logic                      rx_bit;
    logic                      bus_owned;
    logic                      slv_stretch;
    logic                      pull_sda;
    logic                      grab_scl;
    logic [16:0]               stretch;
    i2cbt_pkg::i2cbt_line_type dut_out;
    i2cbt_pkg::i2cbt_line_type dut_oe;
    i2cbt_pkg::i2cbt_line_type peer_oe;
    i2cbt_pkg::i2cbt_line_type lvl;
    logic                      scl_p;
    logic                      sda_p;
    logic [31:0]               lo_n, hi_n, st_n, lo_s, hi_s, hd_s, su_s, rs_s, sh_s;
    logic [31:0]               r, h, hd, sh;
    logic [63:0]               tbl [6];
    int                        i;
    int                        n;
    int                        fails;
    int                        n_compared;

    // Released lines float up through the pull-ups
    assign lvl.scl = (dut_oe.scl ? dut_out.scl : 1'b1) & ~peer_oe.scl;
    assign lvl.sda = (dut_oe.sda ? dut_out.sda : 1'b1) & ~peer_oe.sda;

    i2cbt_gen i2cbt_gen_inst (
        .clk                  (clk),
        .sys_rst              (sys_rst),
        .divider_select_field (dsel),
        .filter_sample_rate   (fsr),
        .cmd_valid            (cmd_valid),
        .cmd_op               (cmd_op),
        .cmd_bit              (cmd_bit),
        .cmd_ready            (cmd_ready),
        .done                 (done),
        .rx_bit               (rx_bit),
        .bus_owned            (bus_owned),
        .slave_tx_stretch     (slv_stretch),
        .line_in              (lvl),
        .line_out             (dut_out),
        .line_oe              (dut_oe)
    );

    i2cbt_bus_peer i2cbt_bus_peer_inst (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .wire_lvl (lvl),
        .pull_sda (pull_sda),
        .grab_scl (grab_scl),
        .stretch  (stretch),
        .peer_oe  (peer_oe)
    );

    always #4 clk = ~clk;

    // Interval lengths on the wires, in clock cycles
    always @(posedge clk)
    begin
        if (lvl.scl !== scl_p)
        begin
            if (lvl.scl)
                lo_s = lo_n;
            else
                hi_s = hi_n;
            if (!lvl.scl)
                sh_s = st_n;
            lo_n = 32'h0;
            hi_n = 32'h0;
        end
        if (lvl.sda !== sda_p)
        begin
            if (!lvl.scl)
                hd_s = lo_n;
            else if (lvl.sda)
                su_s = hi_n;
            else
                rs_s = hi_n;
            st_n = 32'h0;
        end
        if (lvl.scl)
            hi_n++;
        else
            lo_n++;
        st_n++;
        scl_p = lvl.scl;
        sda_p = lvl.sda;
    end

    task automatic tally_and_finish;
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Timings are minimums, so a small window above each is accepted
    task automatic rng(input logic [31:0] seen, input logic [31:0] lo, input logic [31:0] hi);
        check(seen, (((seen >= lo) && (seen <= hi)) === 1'b1) ? seen : lo);
    endtask : rng

    task automatic step;
        @(posedge clk);
        #1;
    endtask : step

    task automatic cmd(input i2cbt_pkg::i2cbt_op_type op, input logic b);
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 32'h10)
        begin
            step();
            k++;
        end
        if (cmd_ready !== 1'b1)
        begin
            fails++;
            tally_and_finish();
        end
        cmd_op = op;
        cmd_bit = b;
        cmd_valid = 1'b1;
        step();
        cmd_valid = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 32'h8000)
        begin
            step();
            k++;
        end
        if (done !== 1'b1)
        begin
            fails++;
            tally_and_finish();
        end
        step();
    endtask : cmd

    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        dsel = 6'h20;
        fsr = 6'h01;
        cmd_valid = 1'b0;
        cmd_op = i2cbt_pkg::OP_START;
        cmd_bit = 1'b1;
        slv_stretch = 1'b0;
        pull_sda = 1'b0;
        grab_scl = 1'b0;
        stretch = 17'h00000;
        scl_p = 1'b1;
        sda_p = 1'b1;
        lo_n = 32'h0;
        hi_n = 32'h0;
        st_n = 32'h0;
        fails = 0;
        n_compared = 0;
        tbl[0] = {8'h20, 8'h01, 16'h0050, 16'h0018, 8'h05, 8'h01};
        tbl[1] = {8'h21, 8'h02, 16'h0060, 16'h0018, 8'h06, 8'h01};
        tbl[2] = {8'h00, 8'h01, 16'h0090, 16'h0038, 8'h09, 8'h01};
        tbl[3] = {8'h01, 8'h03, 16'h00a0, 16'h0038, 8'h0a, 8'h01};
        tbl[4] = {8'h1e, 8'h01, 16'h6000, 16'h2008, 8'h0c, 8'h00};
        tbl[5] = {8'h1f, 8'h01, 16'h7800, 16'h2008, 8'h0f, 8'h00};
        repeat (8) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        check(32'({dut_oe, cmd_ready, bus_owned, rx_bit, done}), 32'h0a);
        for (i = 0; i < 32'h6; i++)
        begin
            dsel = tbl[i][61:56];
            fsr = tbl[i][53:48];
            r = 32'(tbl[i][55:48]);
            h = 32'(tbl[i][47:32]);
            hd = 32'(tbl[i][31:16]);
            sh = 32'(tbl[i][15:8]);
            repeat (8) step();
            cmd(i2cbt_pkg::OP_START, 1'b0);
            rng(sh_s, sh, sh + 32'h2);
            if (tbl[i][0])
            begin
                cmd(i2cbt_pkg::OP_BIT, 1'b1);
                rng(hd_s, hd, hd + 32'h4);
                check(32'(rx_bit), 32'h1);
                // Peer answers the third bit low and stretches its clock
                pull_sda = 1'b1;
                stretch = 17'(h) + 17'h00014;
                cmd(i2cbt_pkg::OP_BIT, 1'b0);
                rng(lo_s, h, h + 32'h4);
                pull_sda = 1'b0;
                stretch = 17'h00000;
                cmd(i2cbt_pkg::OP_BIT, 1'b1);
                check(32'(rx_bit), 32'h0);
                rng(hi_s, h + r + 32'h1, h + r + r + 32'h3);
                if (i == 0)
                begin
                    cmd(i2cbt_pkg::OP_START, 1'b0);
                    rng(rs_s, h + h + sh + r + 32'h1, h + h + sh + r + r + 32'h3);
                    rng(sh_s, sh, sh + 32'h2);
                end
            end
            cmd(i2cbt_pkg::OP_STOP, 1'b0);
            rng(su_s, r + 32'h5, r + r + 32'h7);
            rng(lo_s, h, h + 32'h4);
            check(32'({bus_owned, dut_oe, dut_out}), 32'h0);
            if (i == 0)
            begin
                slv_stretch = 1'b1;
                grab_scl = 1'b1;
                n = 0;
                while (dut_oe.scl !== 1'b1 && n < 32'hc8)
                begin
                    step();
                    n++;
                end
                rng(32'(n), r + 32'h19, r + r + 32'h1d);
                if (n == 32'hc8)
                    tally_and_finish();
                grab_scl = 1'b0;
                slv_stretch = 1'b0;
                repeat (8) step();
                check(32'(dut_oe.scl), 32'h0);
            end
        end
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
